// ### hdl/vbisp_pkg.sv
/*
 Shared constants and carrier types for the video buffer serial slave port.
 Assumes a 25 MHz system clock sampling the two-wire bus pins.
*/
package vbisp_pkg;
	localparam logic [4:0] VBISP_ADDR_FIXED = 5'h0B;
	localparam int VBISP_ADDR_FIXED_W = 5;
	localparam int VBISP_BYTE_W = 8;
	localparam logic [3:0] VBISP_BIT_LAST = 4'h7;
	localparam logic [3:0] VBISP_BIT_FIRST = 4'h0;
	localparam logic [7:0] VBISP_RESET_BYTE = 8'h00;
	localparam int VBISP_CLK_MHZ = 25;
	localparam int VBISP_SYNC_STAGES = 2;

	typedef struct packed {
		logic scl;
		logic sda;
	} vbisp_bus_t;

	typedef struct packed {
		logic [7:0] subaddr;
		logic [7:0] data;
	} vbisp_wr_t;

	typedef enum logic [2:0] {
		VBISP_IDLE,
		VBISP_ADDR,
		VBISP_ACK,
		VBISP_RX,
		VBISP_TX,
		VBISP_MACK,
		VBISP_HOLD
	} vbisp_state_t;
endpackage

// ### hdl/vbisp_sync.sv
/*
 Two-stage synchroniser for a vector of bus pins.
 Assumes the inputs are asynchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module vbisp_sync #(
	parameter int W = 2
) (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, high
	input wire logic [W-1:0] din, // raw pins
	output logic [W-1:0] dout // synchronised copy
);
	logic [W-1:0] meta_reg;

	// first stage feeds only the second; idle bus is high
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '1;
			dout <= '1;
		end else begin
			meta_reg <= din;
			dout <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ### hdl/vbisp_top.sv
/*
 Two-wire slave port of a three-channel video buffer: start/stop detection,
 address match, one subaddress plus one data byte per write, one byte per read.
 Assumes an external master drives the clock line and that the register file
 lives outside, reached through wr_* strobes and rd_data.
*/
// Notes on behaviour
// - data falling while clock high starts
// - data changes only while clock low
// - acknowledge only on address match
// - eight bits msb first, ninth acknowledges
// - data rising while clock high stops
// - after stop, idle until matched start
// - transmitter releases data during acknowledge
// - receiver pulls data low each byte up to a write's data byte; later bytes get none
// - one register written per transfer
// - read: address acked, master acknowledges bytes
// - only one byte returned per read
// - first byte after start is address
// - address 01011, select pins, direction
// - select pins used live, not latched
// - works at standard and fast rates
// - lines open-drain, released when idle
// - write: address, subaddress, one data byte
`timescale 1ns/100ps
`default_nettype none
module vbisp_top (
	input wire logic clk, // 25 MHz system clock
	input wire logic rst, // async reset, high
	input wire logic scl_in, // serial clock pin level
	input wire logic sda_in, // serial data pin level
	output logic sda_out, // data drive level, always low
	output logic sda_oe, // high while pulling data low
	output logic scl_out, // clock drive level, unused
	output logic scl_oe, // never drives clock
	input wire logic address_select_upper_pin, // address bit 2
	input wire logic address_select_lower_pin, // address bit 1
	output logic [7:0] wr_subaddr, // subaddress of last write
	output logic [7:0] wr_data, // data of last write
	output logic wr_strobe, // one-cycle write pulse
	output logic [7:0] rd_subaddr, // subaddress for reads
	input wire logic [7:0] rd_data, // register contents at rd_subaddr
	output logic busy // transfer in progress from start, before address match too
);
	vbisp_pkg::vbisp_bus_t pin_sync;
	vbisp_pkg::vbisp_bus_t pin_prev;
	logic [1:0] sel_meta_reg;
	logic [1:0] sel_reg;
	vbisp_pkg::vbisp_state_t state_reg;
	logic [3:0] bit_reg;
	logic [7:0] shift_reg;
	logic rw_reg;
	logic sub_done_reg;
	logic data_done_reg;
	logic sda_oe_reg;
	logic [7:0] sub_reg;
	vbisp_pkg::vbisp_wr_t wr_reg;
	logic strobe_reg;
	logic busy_reg;
	logic sda_out_reg;
	logic scl_out_reg;
	logic scl_oe_reg;

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic in_byte;
	logic byte_end;
	logic addr_end;
	logic rx_end;
	logic addr_ok;
	logic rd_start;

	function automatic logic addr_match(input logic [7:0] b, input logic [1:0] sel);
		addr_match = (b[7:3] == vbisp_pkg::VBISP_ADDR_FIXED) && (b[2:1] == sel);
	endfunction

	vbisp_sync #(
		.W(vbisp_pkg::VBISP_SYNC_STAGES)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.din({scl_in, sda_in}),
		.dout(pin_sync)
	);

	// select pins sampled continuously, never latched per transfer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sel_meta_reg <= 2'h0;
			sel_reg <= 2'h0;
		end else begin
			sel_meta_reg <= {address_select_upper_pin, address_select_lower_pin};
			sel_reg <= sel_meta_reg;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_prev <= '1;
		end else begin
			pin_prev <= pin_sync;
		end
	end

	// at 25 MHz a fast-mode high phase spans ~15 samples, so edges are seen
	assign scl_rise = pin_sync.scl && !pin_prev.scl;
	assign scl_fall = !pin_sync.scl && pin_prev.scl;
	// data only legal to move with clock low; a move with clock high is framing
	assign start_det = pin_sync.scl && pin_prev.scl && pin_prev.sda && !pin_sync.sda;
	assign stop_det = pin_sync.scl && pin_prev.scl && !pin_prev.sda && pin_sync.sda;

	// byte boundaries, shared by the state, counter, flag and drive logic
	assign in_byte = (state_reg == vbisp_pkg::VBISP_ADDR)
		|| (state_reg == vbisp_pkg::VBISP_RX);
	assign byte_end = in_byte && scl_fall && (bit_reg == vbisp_pkg::VBISP_BIT_LAST);
	assign addr_end = byte_end && (state_reg == vbisp_pkg::VBISP_ADDR);
	assign rx_end = byte_end && (state_reg == vbisp_pkg::VBISP_RX);
	assign addr_ok = addr_match(shift_reg, sel_reg);
	assign rd_start = (state_reg == vbisp_pkg::VBISP_ACK) && scl_fall
		&& rw_reg && !sub_done_reg;

	// one block per concern; stop outranks start, start outranks the byte flow
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= vbisp_pkg::VBISP_IDLE;
		end else if (stop_det) begin
			state_reg <= vbisp_pkg::VBISP_IDLE;
		end else if (start_det) begin
			state_reg <= vbisp_pkg::VBISP_ADDR;
		end else begin
			case (state_reg)
				vbisp_pkg::VBISP_IDLE: begin
					state_reg <= vbisp_pkg::VBISP_IDLE;
				end
				vbisp_pkg::VBISP_ADDR: begin
					if (byte_end) begin
						if (addr_ok) begin
							state_reg <= vbisp_pkg::VBISP_ACK;
						end else begin
							state_reg <= vbisp_pkg::VBISP_IDLE;
						end
					end
				end
				vbisp_pkg::VBISP_RX: begin
					if (byte_end) begin
						if (data_done_reg) begin
							state_reg <= vbisp_pkg::VBISP_HOLD;
						end else begin
							state_reg <= vbisp_pkg::VBISP_ACK;
						end
					end
				end
				vbisp_pkg::VBISP_ACK: begin
					if (scl_fall) begin
						if (rd_start) begin
							state_reg <= vbisp_pkg::VBISP_TX;
						end else begin
							state_reg <= vbisp_pkg::VBISP_RX;
						end
					end
				end
				vbisp_pkg::VBISP_TX: begin
					if (scl_fall && bit_reg == vbisp_pkg::VBISP_BIT_LAST) begin
						state_reg <= vbisp_pkg::VBISP_MACK;
					end
				end
				vbisp_pkg::VBISP_MACK: begin
					// master's acknowledge or not: either way no further byte
					if (scl_fall) begin
						state_reg <= vbisp_pkg::VBISP_HOLD;
					end
				end
				vbisp_pkg::VBISP_HOLD: begin
					state_reg <= vbisp_pkg::VBISP_HOLD;
				end
				default: begin
					state_reg <= vbisp_pkg::VBISP_IDLE;
				end
			endcase
		end
	end

	// the start's own clock fall is no data bit, so count from one below
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bit_reg <= vbisp_pkg::VBISP_BIT_FIRST;
		end else if (stop_det) begin
			bit_reg <= vbisp_pkg::VBISP_BIT_FIRST;
		end else if (start_det) begin
			bit_reg <= vbisp_pkg::VBISP_BIT_FIRST - 4'h1;
		end else if (scl_fall && (in_byte || state_reg == vbisp_pkg::VBISP_TX)) begin
			if (bit_reg == vbisp_pkg::VBISP_BIT_LAST) begin
				bit_reg <= vbisp_pkg::VBISP_BIT_FIRST;
			end else begin
				bit_reg <= bit_reg + 4'h1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shift_reg <= vbisp_pkg::VBISP_RESET_BYTE;
		end else if (!stop_det && !start_det) begin
			if (in_byte && scl_rise) begin
				shift_reg <= {shift_reg[6:0], pin_sync.sda};
			end else if (rd_start) begin
				shift_reg <= {rd_data[6:0], 1'b0};
			end else if (state_reg == vbisp_pkg::VBISP_TX && scl_fall) begin
				shift_reg <= {shift_reg[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rw_reg <= 1'b0;
		end else if (!stop_det && !start_det && addr_end && addr_ok) begin
			rw_reg <= shift_reg[0];
		end
	end

	// flags say which bytes of this transfer have been taken
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sub_done_reg <= 1'b0;
			data_done_reg <= 1'b0;
		end else if (start_det) begin
			sub_done_reg <= 1'b0;
			data_done_reg <= 1'b0;
		end else if (!stop_det) begin
			if (rx_end && !data_done_reg) begin
				if (sub_done_reg) begin
					data_done_reg <= 1'b1;
				end else begin
					sub_done_reg <= 1'b1;
				end
			end else if (rd_start) begin
				sub_done_reg <= 1'b1;
			end
		end
	end

	// drive changes only follow a synchronised clock fall, so they land with clock low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sda_oe_reg <= 1'b0;
		end else if (stop_det || start_det) begin
			sda_oe_reg <= 1'b0;
		end else begin
			case (state_reg)
				vbisp_pkg::VBISP_ADDR: begin
					if (byte_end && addr_ok) begin
						sda_oe_reg <= 1'b1;
					end
				end
				vbisp_pkg::VBISP_RX: begin
					if (byte_end && !data_done_reg) begin
						sda_oe_reg <= 1'b1;
					end
				end
				vbisp_pkg::VBISP_ACK: begin
					// hold low through the whole ninth high phase; on its fall release, or drive a read's first bit
					if (rd_start) begin
						sda_oe_reg <= !rd_data[vbisp_pkg::VBISP_BYTE_W-1];
					end else if (scl_fall) begin
						sda_oe_reg <= 1'b0;
					end
				end
				vbisp_pkg::VBISP_TX: begin
					if (scl_fall) begin
						if (bit_reg == vbisp_pkg::VBISP_BIT_LAST) begin
							sda_oe_reg <= 1'b0;
						end else begin
							sda_oe_reg <= !shift_reg[7];
						end
					end
				end
				vbisp_pkg::VBISP_MACK: begin
					sda_oe_reg <= 1'b0;
				end
				default: begin
					sda_oe_reg <= 1'b0;
				end
			endcase
		end
	end

	// status leaves from a flop; lags the state by one cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= (state_reg != vbisp_pkg::VBISP_IDLE);
		end
	end

	// open-drain: only ever pull low, and the clock line is never pulled
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sda_out_reg <= 1'b0;
			scl_out_reg <= 1'b0;
			scl_oe_reg <= 1'b0;
		end else begin
			sda_out_reg <= 1'b0;
			scl_out_reg <= 1'b0;
			scl_oe_reg <= 1'b0;
		end
	end

	// subaddress kept across transfers so a later read uses it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sub_reg <= vbisp_pkg::VBISP_RESET_BYTE;
			wr_reg <= '0;
			strobe_reg <= 1'b0;
		end else begin
			strobe_reg <= 1'b0;
			if (!stop_det && !start_det && state_reg == vbisp_pkg::VBISP_RX && scl_fall
					&& bit_reg == vbisp_pkg::VBISP_BIT_LAST && !data_done_reg) begin
				if (!sub_done_reg) begin
					sub_reg <= shift_reg;
				end else begin
					wr_reg.subaddr <= sub_reg;
					wr_reg.data <= shift_reg;
					strobe_reg <= 1'b1;
				end
			end
		end
	end

	assign sda_out = sda_out_reg;
	assign sda_oe = sda_oe_reg;
	assign scl_out = scl_out_reg;
	assign scl_oe = scl_oe_reg;
	assign wr_subaddr = wr_reg.subaddr;
	assign wr_data = wr_reg.data;
	assign wr_strobe = strobe_reg;
	assign rd_subaddr = sub_reg;
	assign busy = busy_reg;
endmodule
`default_nettype wire

// ### sim/vbisp_assertions.sv
/* Checker on the slave port pins and write strobe.
 Bound to vbisp_top; sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
module vbisp_assertions (
	input wire logic clk, // system clock
	input wire logic rst, // async reset
	input wire logic scl_in, // clock wire
	input wire logic sda_in, // data wire
	input wire logic sda_out, // data level
	input wire logic sda_oe, // data pull
	input wire logic scl_oe, // clock pull
	input wire logic wr_strobe, // write pulse
	input wire logic busy // transfer on
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_clock_never_driven: assert property (!scl_oe)
		else $error("clock driven");
	a_data_pull_low: assert property (sda_oe |-> !sda_out)
		else $error("data driven high");
	a_idle_releases: assert property (!busy |-> !sda_oe)
		else $error("idle but driving");
	a_moves_clock_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data moved in clock high");
	a_pull_holds: assert property ($rose(sda_oe) |-> sda_oe[*6])
		else $error("pull too short");
	a_strobe_pulse: assert property (wr_strobe |=> !wr_strobe)
		else $error("strobe too long");
	a_strobe_busy: assert property (wr_strobe |-> busy)
		else $error("strobe outside transfer");
	a_stop_idles: assert property ($rose(sda_in) && scl_in |-> ##[1:6] !busy)
		else $error("stop not seen");
	cover property (wr_strobe);
	cover property ($rose(sda_oe));
	cover property ($fell(busy));
endmodule
bind vbisp_top vbisp_assertions i_vbisp_assertions (.clk, .rst, .scl_in,
	.sda_in, .sda_out, .sda_oe, .scl_oe, .wr_strobe, .busy);
`default_nettype wire

// ### sim/vbisp_master.sv
/* Bus master model: drives clock and data as open-drain pulls.
 Assumes the bench resolves both wires with pull-ups. */
`timescale 1ns/100ps
`default_nettype none
module vbisp_master (
	input wire logic clk, // system clock
	input wire logic sda_in, // resolved data
	output logic scl, // 0 pulls clock
	output logic sda // 0 pulls data
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
	endtask
	// 4 clk low, 4 clk high: 320 ns a bit
	task automatic start();
		sda <= 1'b1;
		tk(2);
		scl <= 1'b1;
		tk(4);
		sda <= 1'b0;
		tk(4);
		scl <= 1'b0;
		tk(2);
	endtask
	task automatic stop();
		sda <= 1'b0;
		tk(2);
		scl <= 1'b1;
		tk(4);
		sda <= 1'b1;
		tk(4);
	endtask
	// eight bits then the acknowledge slot; 1 releases
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			sda <= tx[i];
			tk(2);
			scl <= 1'b1;
			tk(4);
			rx[i] = sda_in;
			scl <= 1'b0;
			tk(2);
		end
	endtask
endmodule
`default_nettype wire

// ### sim/vbisp_top_bench.sv
/* Bench for the slave port: writes, address select, reads, abort.
 Assumes vbisp_master as bus master and a pull-up on each wire. */
`timescale 1ns/100ps
`default_nettype none
module vbisp_top_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] sel = 2'h0;
	logic [7:0] rd_data = 8'h00;
	logic m_scl, m_sda, sda_oe, scl_oe, sda_out, scl_out, wr_strobe, busy;
	logic [7:0] wr_subaddr, wr_data, rd_subaddr;
	logic [8:0] rx;
	int err_count = 0;
	int n_compared = 0;
	int n_str = 0;
	wire logic scl_in = m_scl & ~(scl_oe & ~scl_out);
	wire logic sda_in = m_sda & ~(sda_oe & ~sda_out);
	always #20 clk = ~clk;
	always @(posedge clk) begin
		rd_data <= rd_subaddr ^ 8'h5A;
		if (wr_strobe === 1'b1) n_str++;
	end
	vbisp_top i_vbisp_top (.clk, .rst, .scl_in, .sda_in, .sda_out, .sda_oe,
		.scl_out, .scl_oe, .address_select_upper_pin(sel[1]),
		.address_select_lower_pin(sel[0]), .wr_subaddr, .wr_data, .wr_strobe,
		.rd_subaddr, .rd_data, .busy);
	vbisp_master i_vbisp_master (.clk, .sda_in, .scl(m_scl), .sda(m_sda));
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] ad(input logic [1:0] p, input logic r);
		return {vbisp_pkg::VBISP_ADDR_FIXED, p, r};
	endfunction
	// a is the expected acknowledge level
	task automatic wb(input logic [7:0] b, input logic a);
		i_vbisp_master.xfer({b, 1'b1}, rx);
		chk({8'h00, rx[0]}, {8'h00, a});
	endtask
	task automatic t_write();
		int s0;
		s0 = n_str;
		i_vbisp_master.start();
		wb(ad(sel, 1'b0), 1'b0);
		wb(8'h03, 1'b0);
		wb(8'hA5, 1'b0);
		wb(8'h3C, 1'b1);
		i_vbisp_master.stop();
		i_vbisp_master.tk(8);
		chk({wr_subaddr, busy}, {8'h03, 1'b0});
		chk({1'b0, wr_data}, 9'h0A5);
		chk(9'(n_str - s0), 9'h001);
	endtask
	task automatic t_addr();
		for (int p = 0; p < 4; p++) begin
			@(posedge clk);
			sel <= 2'(p);
			i_vbisp_master.tk(4);
			i_vbisp_master.start();
			wb(ad(2'(p) ^ 2'h1, 1'b0), 1'b1);
			i_vbisp_master.start();
			wb(ad(2'(p), 1'b0), 1'b0);
			i_vbisp_master.stop();
		end
	endtask
	task automatic t_read();
		i_vbisp_master.start();
		wb(ad(sel, 1'b0), 1'b0);
		wb(8'h04, 1'b0);
		i_vbisp_master.stop();
		i_vbisp_master.start();
		wb(ad(sel, 1'b1), 1'b0);
		i_vbisp_master.xfer(9'h1FE, rx);
		chk(rx, {8'h04 ^ 8'h5A, 1'b0});
		i_vbisp_master.xfer(9'h1FF, rx);
		chk(rx, 9'h1FF);
		i_vbisp_master.stop();
		i_vbisp_master.tk(8);
		chk({rd_subaddr, busy}, {8'h04, 1'b0});
	endtask
	task automatic t_abort();
		i_vbisp_master.start();
		wb(ad(sel, 1'b0), 1'b0);
		i_vbisp_master.stop();
		i_vbisp_master.tk(8);
		chk({8'h00, busy}, 9'h000);
	endtask
	task automatic give_verdict();
		if (err_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		t_write();
		t_addr();
		t_read();
		t_abort();
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		give_verdict();
	end
endmodule
`default_nettype wire
